// ---- omam_pkg.sv ----
// Package: constants and carriers for the operating-mode and address-map block
package omam_pkg;

    // Startup operating modes
    typedef enum logic [2:0] {
        OMAM_MODE_SINGLE,
        OMAM_MODE_BOOT_SERIAL,
        OMAM_MODE_BOOT_USB,
        OMAM_MODE_USER_BOOT
    } omam_mode_e;

    // Address map regions
    typedef enum logic [3:0] {
        OMAM_RGN_NONE,
        OMAM_RGN_RAM,
        OMAM_RGN_PERIPH,
        OMAM_RGN_STBY_RAM,
        OMAM_RGN_DATA_FLASH,
        OMAM_RGN_OPTION_MEM,
        OMAM_RGN_FLASH_SEQ_RAM,
        OMAM_RGN_FLASH_REGS,
        OMAM_RGN_ECC_RAM,
        OMAM_RGN_EXT_CS,
        OMAM_RGN_EXT_SDRAM,
        OMAM_RGN_USER_BOOT_ROM,
        OMAM_RGN_PROGRAM_ROM
    } omam_region_e;

    // Software write to the system mode register
    typedef struct packed {
        logic romEnable;
        logic extBusEnable;
    } omam_sysmode_s;

    // Decoder answer
    typedef struct packed {
        omam_region_e region;
        logic [2:0]   csIndex;
        logic         csSel;
    } omam_decode_s;

    // Reset values of the system mode register and privilege mode bit, plus supervisor encoding
    localparam logic ROM_ENABLE_RST  = 1'b1;
    localparam logic EXT_BUS_EN_RST  = 1'b0;
    localparam logic PRIV_MODE_RST   = 1'b0;
    localparam logic PRIV_SUPERVISOR = 1'b0;

    // Address map boundaries
    localparam logic [31:0] ADDR_RAM_BASE        = 32'h0000_0000;
    localparam logic [31:0] ADDR_PERIPH0_BASE    = 32'h0008_0000;
    localparam logic [31:0] ADDR_PERIPH0_LAST    = 32'h000A_3FFF;
    localparam logic [31:0] ADDR_PERIPH1_BASE    = 32'h000A_6000;
    localparam logic [31:0] ADDR_PERIPH1_LAST    = 32'h000F_FFFF;
    localparam logic [31:0] ADDR_DATA_FLASH_BASE = 32'h0010_0000;
    localparam logic [31:0] ADDR_DATA_FLASH_END  = 32'h0011_0000;
    localparam logic [31:0] ADDR_OPTION_BASE     = 32'h0012_0040;
    localparam logic [31:0] ADDR_OPTION_END      = 32'h0012_0070;
    localparam logic [31:0] ADDR_FSEQ_RAM_BASE   = 32'h007F_8000;
    localparam logic [31:0] ADDR_FSEQ_RAM_END    = 32'h007F_9000;
    localparam logic [31:0] ADDR_FLASH_REGS_BASE = 32'h007F_E000;
    localparam logic [31:0] ADDR_FLASH_REGS_LAST = 32'h007F_FFFF;
    localparam logic [31:0] ADDR_ECC_RAM_BASE    = 32'h00FF_8000;
    localparam logic [31:0] ADDR_EXT_LO_BASE     = 32'h0100_0000;
    localparam logic [31:0] ADDR_SDRAM_BASE      = 32'h0800_0000;
    localparam logic [31:0] ADDR_EXT_LO_LAST     = 32'h0FFF_FFFF;
    localparam logic [31:0] ADDR_EXT_HI_BASE     = 32'hFF00_0000;
    localparam logic [31:0] ADDR_USER_BOOT_BASE  = 32'hFF7F_8000;
    localparam logic [31:0] ADDR_USER_BOOT_END   = 32'hFF80_0000;
    localparam logic [31:0] ADDR_PROG_ROM_BASE   = 32'hFFC0_0000;

    // Chip-select window size exponent (16 MB)
    localparam int CS_WINDOW_SHIFT = 24;
    // Strap pin filter depth (three flops)
    localparam int PIN_SYNC_STAGES = 3;

endpackage

// ---- omam_addr_decode.sv ----
// Address decoder for the operating-mode dependent memory map
`timescale 1ns/1ns
module omam_addr_decode
    import omam_pkg::*;
(
    // Mode
    input  wire logic         romOn,
    input  wire logic         extOn,
    // Address
    input  wire logic [31:0]  addr,
    // Answer
    output omam_decode_s      dec
);

    wire inRam       = addr < ADDR_PERIPH0_BASE;
    wire inPeriph    = (addr >= ADDR_PERIPH0_BASE && addr <= ADDR_PERIPH0_LAST)
                     || (addr >= ADDR_PERIPH1_BASE && addr <= ADDR_PERIPH1_LAST);
    wire inStby      = addr > ADDR_PERIPH0_LAST && addr < ADDR_PERIPH1_BASE;
    wire inDataFlash = addr >= ADDR_DATA_FLASH_BASE && addr < ADDR_DATA_FLASH_END;
    wire inOption    = addr >= ADDR_OPTION_BASE && addr < ADDR_OPTION_END;
    wire inFseqRam   = addr >= ADDR_FSEQ_RAM_BASE && addr < ADDR_FSEQ_RAM_END;
    wire inFlashRegs = addr >= ADDR_FLASH_REGS_BASE && addr <= ADDR_FLASH_REGS_LAST;
    wire inEccRam    = addr >= ADDR_ECC_RAM_BASE && addr < ADDR_EXT_LO_BASE;
    wire inExtLo     = addr >= ADDR_EXT_LO_BASE && addr <= ADDR_EXT_LO_LAST;
    wire inSdram     = addr >= ADDR_SDRAM_BASE && addr <= ADDR_EXT_LO_LAST;
    wire inExtHi     = addr >= ADDR_EXT_HI_BASE;
    wire inUserBoot  = addr >= ADDR_USER_BOOT_BASE && addr < ADDR_USER_BOOT_END;
    wire inProgRom   = addr >= ADDR_PROG_ROM_BASE;
    // On-chip ROM enable turns window zero off over its whole range, not only the ROM areas
    wire romHit      = romOn && (inUserBoot || inProgRom);
    wire extHiHit    = extOn && inExtHi && !romOn;
    wire extLoHit    = extOn && inExtLo && !inSdram;
    wire sdramHit    = extOn && inSdram;

    always_comb begin
        dec = '0;
        if (inRam) begin
            dec.region = OMAM_RGN_RAM;
        end else if (inPeriph) begin
            dec.region = OMAM_RGN_PERIPH;
        end else if (inStby) begin
            dec.region = OMAM_RGN_STBY_RAM;
        end else if (inDataFlash) begin
            dec.region = OMAM_RGN_DATA_FLASH;
        end else if (inOption) begin
            dec.region = OMAM_RGN_OPTION_MEM;
        end else if (inFseqRam) begin
            dec.region = OMAM_RGN_FLASH_SEQ_RAM;
        end else if (inFlashRegs) begin
            dec.region = OMAM_RGN_FLASH_REGS;
        end else if (inEccRam) begin
            dec.region = OMAM_RGN_ECC_RAM;
        end else if (sdramHit) begin
            dec.region = OMAM_RGN_EXT_SDRAM;
        end else if (extLoHit) begin
            dec.region  = OMAM_RGN_EXT_CS;
            dec.csSel   = 1'b1;
            dec.csIndex = 3'(~addr[26:CS_WINDOW_SHIFT]);
        end else if (romHit) begin
            dec.region = inProgRom ? OMAM_RGN_PROGRAM_ROM : OMAM_RGN_USER_BOOT_ROM;
        end else if (extHiHit) begin
            dec.region  = OMAM_RGN_EXT_CS;
            dec.csSel   = 1'b1;
            dec.csIndex = 3'h0;
        end
    end

endmodule

// ---- omam_mode_ctrl.sv ----
// Operating-mode, processor-mode and address-map control
`timescale 1ns/1ns
// What this block does
// - Strap pins are filtered and caught once, five cycles after reset release, to choose the startup mode.
// - Boot select high at release gives single-chip mode, user boot ignored.
// - Both pins low give serial boot; ROM reprogrammed over serial interface.
// - Boot select low, user boot high gives USB boot or user boot program.
// - Both boot modes run the boot program from its internal area.
// - User boot mode runs its program and is reachable only after reset.
// - Mode bits with external bus off mean single-chip or user boot.
// - ROM off, bus on: on-chip ROM disabled, external space enabled.
// - ROM on, bus on: on-chip ROM and the external space below 1000 0000h enabled.
// - Single-chip start keeps the external space disabled until software sets external bus enable.
// - After reset ROM enable reads 1 and external bus enable 0.
// - Once ROM enable is cleared it cannot be set again until reset.
// - Mode register writes are blocked unless protect bit one is set.
// - RAM from zero, peripherals in two ranges, standby RAM between.
// - Flash control registers alone occupy the top window below 0080 0000h.
// - Data flash, option memory and program ROM at their fixed bases.
// - User boot ROM, flash-sequencer RAM and ECC RAM at fixed bases.
// - External space: eight 16 MB chip-select windows plus 128 MB SDRAM.
// - ROM-enabled extended mode gives the high range to on-chip ROM.
// - Reset and exceptions enter supervisor mode; return restores prior mode.
// - User mode is reached by return with the saved privilege bit set.
// - User mode blocks privileged instructions and protected status writes.
// - Software traps bring user mode back to supervisor mode.
module omam_mode_ctrl
    import omam_pkg::*;
(
    // Clock and reset
    input  wire logic          core_clk,
    input  wire logic          rstn,

    // Board strapping pins
    input  wire logic          boot_select_pin,
    input  wire logic          user_boot_pin,

    // System mode register write port
    input  wire logic          sysModeWrite,
    input  wire omam_sysmode_s sysModeWdata,
    input  wire logic          protect_bit_one,

    // Processor events
    input  wire logic          exceptionTaken,
    input  wire logic          exceptionReturn,
    input  wire logic          savedPrivMode,
    input  wire logic          break_trap_instruction,
    input  wire logic          privilegedInsn,
    input  wire logic          statusWordWrite,

    // Address to decode
    input  wire logic [31:0]   accessAddr,

    // Mode state
    output omam_mode_e         startMode,
    output logic               modeValid,
    output logic               rom_enable_bit,
    output logic               external_bus_enable_bit,
    output logic               romDisabledExtMode,
    output logic               romEnabledExtMode,
    output logic               runBootProgram,
    output logic               serialBootActive,
    output logic               usbBootActive,
    output logic               userBootActive,

    // Processor mode
    output logic               privilege_mode_bit,
    output logic               privInsnFault,
    output logic               statusWriteBlocked,

    // Decoder result
    output omam_decode_s       decode
);

    default clocking assertClk @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    // Strap filter: three flops, accept once stages two and three agree
    logic [PIN_SYNC_STAGES-1:0] bootSelSync_r;
    logic [PIN_SYNC_STAGES-1:0] userBootSync_r;
    logic                        bootSelStable_r;
    logic                        userBootStable_r;
    logic                        settle_r;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            bootSelSync_r  <= '0;
            userBootSync_r <= '0;
        end else begin
            bootSelSync_r  <= {bootSelSync_r[PIN_SYNC_STAGES-2:0], boot_select_pin};
            userBootSync_r <= {userBootSync_r[PIN_SYNC_STAGES-2:0], user_boot_pin};
        end
    end

    wire bootSelAgree  = bootSelSync_r[1] == bootSelSync_r[2];
    wire userBootAgree = userBootSync_r[1] == userBootSync_r[2];

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            bootSelStable_r  <= 1'b0;
            userBootStable_r <= 1'b0;
            settle_r         <= 1'b0;
        end else begin
            bootSelStable_r  <= bootSelAgree ? bootSelSync_r[2] : bootSelStable_r;
            userBootStable_r <= userBootAgree ? userBootSync_r[2] : userBootStable_r;
            settle_r         <= 1'b1;
        end
    end

    // Pins are filled through the filter before the mode is caught once
    logic [2:0] fillCnt_r;
    wire        fillDone = fillCnt_r == 3'(PIN_SYNC_STAGES + 1);

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            fillCnt_r <= '0;
        end else if (!fillDone) begin
            fillCnt_r <= fillCnt_r + 3'h1;
        end
    end

    wire        captureNow = fillDone && !modeValid;
    omam_mode_e strapMode;
    assign strapMode = bootSelStable_r ? OMAM_MODE_SINGLE
                     : (userBootStable_r ? OMAM_MODE_BOOT_USB : OMAM_MODE_BOOT_SERIAL);

    // startup mode caught once after release; never caught as OMAM_MODE_USER_BOOT
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            startMode <= OMAM_MODE_SINGLE;
            modeValid <= 1'b0;
        end else if (captureNow) begin
            startMode <= strapMode;
            modeValid <= 1'b1;
        end
    end

    // writes gated by protect bit one
    wire writeAllowed = sysModeWrite && protect_bit_one;

    wire romEnNxt     = rom_enable_bit & sysModeWdata.romEnable;

    // single-chip start with no software change keeps bus off
    wire extEnNxt     = sysModeWdata.extBusEnable;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rom_enable_bit          <= ROM_ENABLE_RST;
            external_bus_enable_bit <= EXT_BUS_EN_RST;
        end else if (writeAllowed) begin
            rom_enable_bit          <= romEnNxt;
            external_bus_enable_bit <= extEnNxt;
        end
    end

    wire romDisExtNxt = !rom_enable_bit && external_bus_enable_bit;
    wire romEnExtNxt  = rom_enable_bit && external_bus_enable_bit;

    // boot program runs in both boot modes
    wire serialNxt    = modeValid && startMode == OMAM_MODE_BOOT_SERIAL;
    wire usbNxt       = modeValid && startMode == OMAM_MODE_BOOT_USB;

    // user boot only from release; once the bus is on it is left for good
    wire userNxt      = usbNxt && !external_bus_enable_bit && !usbBootActive;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            romDisabledExtMode <= 1'b0;
            romEnabledExtMode  <= 1'b0;
            serialBootActive   <= 1'b0;
            usbBootActive      <= 1'b0;
            runBootProgram     <= 1'b0;
            userBootActive     <= 1'b0;
        end else begin
            romDisabledExtMode <= romDisExtNxt;
            romEnabledExtMode  <= romEnExtNxt;
            serialBootActive   <= serialNxt;
            usbBootActive      <= usbNxt && !userNxt;
            runBootProgram     <= serialNxt || (usbNxt && !userNxt);
            userBootActive     <= userNxt;
        end
    end

    logic privNxt;
    always_comb begin
        privNxt = privilege_mode_bit;
        if (exceptionTaken || break_trap_instruction) begin
            privNxt = PRIV_SUPERVISOR;
        end else if (exceptionReturn) begin
            privNxt = savedPrivMode;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            privilege_mode_bit <= PRIV_MODE_RST;
        end else begin
            privilege_mode_bit <= privNxt;
        end
    end

    wire inUser = privilege_mode_bit != PRIV_SUPERVISOR;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            privInsnFault      <= 1'b0;
            statusWriteBlocked <= 1'b0;
        end else begin
            privInsnFault      <= inUser && privilegedInsn;
            statusWriteBlocked <= inUser && statusWordWrite;
        end
    end

    omam_decode_s decodeNxt;
    omam_addr_decode u_decode (
        .romOn (rom_enable_bit),
        .extOn (external_bus_enable_bit),
        .addr  (accessAddr),
        .dec   (decodeNxt)
    );

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            decode <= '0;
        end else begin
            decode <= decodeNxt;
        end
    end

    // Assertions
    // ROM enable never rises after reset
    rom_no_rise_a: assert property (
        !$rose(rom_enable_bit)
    )
    else begin
        $error("ROM enable rose after being cleared");
    end

    write_protect_a: assert property (
        (sysModeWrite && !protect_bit_one)
            |=> $stable(external_bus_enable_bit)
    )
    else begin
        $error("Mode register changed while protected");
    end

    // refused ROM set still moves the bus bit
    bus_update_a: assert property (
        (writeAllowed && !rom_enable_bit) |=> (external_bus_enable_bit == $past(sysModeWdata.extBusEnable))
            && !rom_enable_bit
    )
    else begin
        $error("Bus enable not updated on refused ROM set");
    end

    // exception gives supervisor mode next cycle
    exc_super_a: assert property (
        exceptionTaken
            |=> !privilege_mode_bit
    )
    else begin
        $error("Exception did not enter supervisor mode");
    end

    ret_restore_a: assert property (
        (exceptionReturn && !exceptionTaken && !break_trap_instruction)
            |=> privilege_mode_bit == $past(savedPrivMode)
    )
    else begin
        $error("Return did not restore privilege mode");
    end

    trap_super_a: assert property (
        break_trap_instruction
            |=> !privilege_mode_bit
    )
    else begin
        $error("Trap did not reach supervisor mode");
    end

    // privileged instruction in user mode faults
    priv_fault_a: assert property (
        (privilege_mode_bit && privilegedInsn)
            |=> privInsnFault
    )
    else begin
        $error("Privileged instruction not refused");
    end

    strap_single_a: assert property (
        (captureNow && bootSelStable_r)
            |=> startMode == OMAM_MODE_SINGLE && modeValid
    )
    else begin
        $error("Single-chip not chosen from strap");
    end

    mode_fixed_a: assert property (
        modeValid
            |=> $stable(startMode) && modeValid
    )
    else begin
        $error("Startup mode changed after capture");
    end

    rom_dis_ext_a: assert property (
        (!rom_enable_bit && external_bus_enable_bit)
            |=> romDisabledExtMode
    )
    else begin
        $error("ROM disabled extended mode not flagged");
    end

    rom_en_ext_a: assert property (
        (rom_enable_bit && external_bus_enable_bit)
            |=> romEnabledExtMode
    )
    else begin
        $error("ROM enabled extended mode not flagged");
    end

    // bus off means no external decode
    no_ext_a: assert property (
        !external_bus_enable_bit
            |=> !decode.csSel
    )
    else begin
        $error("External window selected with bus off");
    end

endmodule

// ---- omam_soft_model.sv ----
// Board strapping and supervising software model facing the mode control block
`timescale 1ns/1ns
module omam_soft_model
    import omam_pkg::*;
(
    // Clock
    input  wire logic     core_clk,
    // Strapping pins
    output logic          boot_select_pin,
    output logic          user_boot_pin,
    // Mode register writes
    output logic          sysModeWrite,
    output omam_sysmode_s sysModeWdata,
    output logic          protect_bit_one,
    // Processor events
    output logic          exceptionTaken,
    output logic          exceptionReturn,
    output logic          savedPrivMode,
    output logic          break_trap_instruction,
    output logic          privilegedInsn,
    output logic          statusWordWrite
);
    initial begin
        {boot_select_pin, user_boot_pin, sysModeWrite, protect_bit_one} = 4'h0;
        sysModeWdata = 2'h0;
        {exceptionTaken, exceptionReturn, break_trap_instruction, privilegedInsn, statusWordWrite} = 5'h00;
        savedPrivMode = 1'b0;
    end

    task automatic tick();
        @(posedge core_clk);
        #1;
    endtask

    // Straps are levels; moved only under reset or to probe late changes
    task automatic set_straps(input logic md, input logic ub);
        boot_select_pin = md;
        user_boot_pin = ub;
    endtask

    task automatic write_mode(input logic prot, input logic rom, input logic ext);
        tick();
        protect_bit_one = prot;
        sysModeWdata = {rom, ext};
        sysModeWrite = 1'b1;
        tick();
        sysModeWrite = 1'b0;
        protect_bit_one = 1'b0;
        // Released data flips so stale values cannot look right
        sysModeWdata = ~{rom, ext};
    endtask

    task automatic fire(input logic [4:0] ev, input logic saved);
        tick();
        {exceptionTaken, exceptionReturn, break_trap_instruction, privilegedInsn, statusWordWrite} = ev;
        savedPrivMode = saved;
        tick();
        {exceptionTaken, exceptionReturn, break_trap_instruction, privilegedInsn, statusWordWrite} = 5'h00;
        savedPrivMode = ~saved;
    endtask
endmodule

// ---- test_operating_mode_address_map.sv ----
// Self-checking bench for the operating-mode and address-map control block
`timescale 1ns/1ns
module test_operating_mode_address_map
    import omam_pkg::*;
;
    typedef struct packed {
        logic [31:0]  addr;
        logic [1:0]   mode;
        omam_region_e rgn;
    } omam_row_s;

    localparam logic [4:0] EV_EXC  = 5'h10;
    localparam logic [4:0] EV_RET  = 5'h08;
    localparam logic [4:0] EV_TRAP = 5'h04;
    localparam logic [4:0] EV_PRIV = 5'h02;
    localparam logic [4:0] EV_STAT = 5'h01;
    localparam int NROWS = 30;
    // Rows grouped by mode {rom, ext}: ROM enable cannot come back once cleared
    localparam omam_row_s ROWS [NROWS] = '{
        '{32'h0000_0100, 2'h2, OMAM_RGN_RAM}, '{32'h0100_0000, 2'h2, OMAM_RGN_NONE},
        '{32'h0800_0000, 2'h2, OMAM_RGN_NONE}, '{32'hFFC0_0000, 2'h2, OMAM_RGN_PROGRAM_ROM},
        '{32'hFF00_0000, 2'h2, OMAM_RGN_NONE}, '{32'h0008_0000, 2'h3, OMAM_RGN_PERIPH},
        '{32'h000A_3FFF, 2'h3, OMAM_RGN_PERIPH}, '{32'h000A_4000, 2'h3, OMAM_RGN_STBY_RAM},
        '{32'h000A_5FFF, 2'h3, OMAM_RGN_STBY_RAM}, '{32'h000A_6000, 2'h3, OMAM_RGN_PERIPH},
        '{32'h000F_FFFF, 2'h3, OMAM_RGN_PERIPH}, '{32'h0010_0000, 2'h3, OMAM_RGN_DATA_FLASH},
        '{32'h0012_0040, 2'h3, OMAM_RGN_OPTION_MEM}, '{32'h007F_8000, 2'h3, OMAM_RGN_FLASH_SEQ_RAM},
        '{32'h007F_DFFF, 2'h3, OMAM_RGN_NONE}, '{32'h007F_E000, 2'h3, OMAM_RGN_FLASH_REGS},
        '{32'h007F_FFFF, 2'h3, OMAM_RGN_FLASH_REGS}, '{32'h00FF_8000, 2'h3, OMAM_RGN_ECC_RAM},
        '{32'h0100_0000, 2'h3, OMAM_RGN_EXT_CS}, '{32'h07FF_FFFF, 2'h3, OMAM_RGN_EXT_CS},
        '{32'h0800_0000, 2'h3, OMAM_RGN_EXT_SDRAM}, '{32'h0FFF_FFFF, 2'h3, OMAM_RGN_EXT_SDRAM},
        '{32'h1000_0000, 2'h3, OMAM_RGN_NONE}, '{32'hFF00_0000, 2'h3, OMAM_RGN_NONE},
        '{32'hFF7F_8000, 2'h3, OMAM_RGN_USER_BOOT_ROM}, '{32'hFFC0_0000, 2'h3, OMAM_RGN_PROGRAM_ROM},
        '{32'hFFFF_FFFF, 2'h3, OMAM_RGN_PROGRAM_ROM}, '{32'hFF00_0000, 2'h1, OMAM_RGN_EXT_CS},
        '{32'hFFFF_FFFF, 2'h1, OMAM_RGN_EXT_CS}, '{32'h0300_0000, 2'h1, OMAM_RGN_EXT_CS}};

    logic          core_clk;
    logic          rstn;
    logic [31:0]   accessAddr;
    logic          boot_select_pin, user_boot_pin, sysModeWrite, protect_bit_one;
    omam_sysmode_s sysModeWdata;
    logic          exceptionTaken, exceptionReturn, savedPrivMode, break_trap_instruction;
    logic          privilegedInsn, statusWordWrite;
    omam_mode_e    startMode;
    logic          modeValid, rom_enable_bit, external_bus_enable_bit, romDisabledExtMode;
    logic          romEnabledExtMode, runBootProgram, serialBootActive, usbBootActive, userBootActive;
    logic          privilege_mode_bit, privInsnFault, statusWriteBlocked;
    omam_decode_s  decode;
    logic [1:0]    cur;
    int            errors = 0;
    int            num_checks = 0;

    omam_soft_model u_sw (.core_clk(core_clk), .boot_select_pin(boot_select_pin),
        .user_boot_pin(user_boot_pin), .sysModeWrite(sysModeWrite), .sysModeWdata(sysModeWdata),
        .protect_bit_one(protect_bit_one), .exceptionTaken(exceptionTaken), .exceptionReturn(exceptionReturn),
        .savedPrivMode(savedPrivMode), .break_trap_instruction(break_trap_instruction),
        .privilegedInsn(privilegedInsn), .statusWordWrite(statusWordWrite));

    omam_mode_ctrl u_dut (.core_clk(core_clk), .rstn(rstn), .boot_select_pin(boot_select_pin),
        .user_boot_pin(user_boot_pin), .sysModeWrite(sysModeWrite), .sysModeWdata(sysModeWdata),
        .protect_bit_one(protect_bit_one), .exceptionTaken(exceptionTaken), .exceptionReturn(exceptionReturn),
        .savedPrivMode(savedPrivMode), .break_trap_instruction(break_trap_instruction),
        .privilegedInsn(privilegedInsn), .statusWordWrite(statusWordWrite), .accessAddr(accessAddr),
        .startMode(startMode), .modeValid(modeValid), .rom_enable_bit(rom_enable_bit),
        .external_bus_enable_bit(external_bus_enable_bit), .romDisabledExtMode(romDisabledExtMode),
        .romEnabledExtMode(romEnabledExtMode), .runBootProgram(runBootProgram),
        .serialBootActive(serialBootActive), .usbBootActive(usbBootActive), .userBootActive(userBootActive),
        .privilege_mode_bit(privilege_mode_bit), .privInsnFault(privInsnFault),
        .statusWriteBlocked(statusWriteBlocked), .decode(decode));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic step();
        @(posedge core_clk);
        #1;
    endtask

    task automatic check_bit(input logic exp, input logic act);
        num_checks++;
        if (act !== exp) begin
            errors++;
            $display("ERROR t=%0t exp=%h act=%h", $time, exp, act);
        end
    endtask

    task automatic check_val(input logic [3:0] exp, input logic [3:0] act);
        num_checks++;
        if (act !== exp) begin
            errors++;
            $display("ERROR t=%0t exp=%h act=%h", $time, exp, act);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks=%0d errors=%0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic do_reset();
        int n;
        rstn = 1'b0;
        repeat (10) step();
        check_bit(1'b1, rom_enable_bit);
        check_bit(1'b0, external_bus_enable_bit);
        check_bit(1'b0, privilege_mode_bit);
        rstn = 1'b1;
        n = 0;
        while (modeValid !== 1'b1 && n < 8) begin
            step();
            n++;
        end
        if (modeValid !== 1'b1) begin
            errors++;
            $display("ERROR t=%0t mode capture timeout exp=%h act=%h", $time, 1'b1, modeValid);
            tally_and_finish();
        end
        check_val(4'h5, 4'(n));
        step();
    endtask

    initial begin
        rstn = 1'b0;
        accessAddr = 32'h0;
        cur = 2'h2;
        // Model idles first
        #1;
        for (int i = 0; i < 3; i++) begin
            u_sw.set_straps(i == 0, i == 2);
            do_reset();
            // Late strap change must not disturb the caught mode
            u_sw.set_straps(i != 0, i != 2);
            repeat (3) step();
            if (i < 2) begin
                check_val(4'((i == 1) ? OMAM_MODE_BOOT_SERIAL : OMAM_MODE_SINGLE), 4'(startMode));
            end else begin
                check_bit(1'b1, startMode inside {OMAM_MODE_BOOT_USB, OMAM_MODE_USER_BOOT});
            end
            check_bit(i == 1, runBootProgram);
            check_bit(i == 1, serialBootActive);
            check_bit(i == 2, userBootActive);
            check_bit(1'b0, usbBootActive);
            u_sw.write_mode(1'b1, 1'b1, 1'b1);
            step();
            check_bit(i == 2, usbBootActive & runBootProgram);
            u_sw.write_mode(1'b1, 1'b1, 1'b0);
            step();
            check_bit(1'b0, userBootActive);
        end
        u_sw.set_straps(1'b1, 1'b1);
        do_reset();
        u_sw.write_mode(1'b0, 1'b0, 1'b1);
        step();
        check_bit(1'b1, rom_enable_bit);
        check_bit(1'b0, external_bus_enable_bit);
        check_bit(1'b0, romDisabledExtMode | romEnabledExtMode);
        for (int i = 0; i < NROWS; i++) begin
            if (ROWS[i].mode !== cur) begin
                cur = ROWS[i].mode;
                u_sw.write_mode(1'b1, cur[1], cur[0]);
                check_bit(cur[1], rom_enable_bit);
                check_bit(cur[0], external_bus_enable_bit);
                step();
                check_bit(cur == 2'h1, romDisabledExtMode);
                check_bit(cur == 2'h3, romEnabledExtMode);
            end
            accessAddr = ROWS[i].addr;
            step();
            check_val(4'(ROWS[i].rgn), 4'(decode.region));
            if (ROWS[i].rgn == OMAM_RGN_EXT_CS) begin
                check_bit(1'b1, decode.csSel);
                check_val(ROWS[i].addr[31] ? 4'h0 : {1'b0, ~ROWS[i].addr[26:24]}, {1'b0, decode.csIndex});
            end
        end
        u_sw.write_mode(1'b1, 1'b1, 1'b0);
        check_bit(1'b0, rom_enable_bit);
        check_bit(1'b0, external_bus_enable_bit);
        step();
        check_bit(1'b0, romDisabledExtMode | romEnabledExtMode);
        u_sw.fire(EV_PRIV | EV_STAT, 1'b0);
        check_bit(1'b0, privInsnFault | statusWriteBlocked);
        u_sw.fire(EV_RET, 1'b1);
        check_bit(1'b1, privilege_mode_bit);
        u_sw.fire(EV_PRIV, 1'b0);
        check_bit(1'b1, privInsnFault);
        check_bit(1'b0, statusWriteBlocked);
        step();
        check_bit(1'b0, privInsnFault);
        u_sw.fire(EV_STAT, 1'b0);
        check_bit(1'b1, statusWriteBlocked);
        u_sw.fire(EV_TRAP, 1'b0);
        check_bit(1'b0, privilege_mode_bit);
        u_sw.fire(EV_RET, 1'b1);
        u_sw.fire(EV_EXC | EV_RET, 1'b1);
        check_bit(1'b0, privilege_mode_bit);
        u_sw.fire(EV_RET, 1'b1);
        check_bit(1'b1, privilege_mode_bit);
        u_sw.fire(EV_RET, 1'b0);
        check_bit(1'b0, privilege_mode_bit);
        do_reset();
        tally_and_finish();
    end

    initial begin
        #200000;
        errors++;
        $display("ERROR t=%0t run timeout exp=%h act=%h", $time, 1'b0, 1'b1);
        tally_and_finish();
    end
endmodule
